/* File: rtl/fic_pkg.sv */
// Package: constants and types for the four level interrupt controller
package fic_pkg;
  localparam int NSRC = 13;
  // Source index order follows enable/priority bit placement
  localparam int SRC_EXT0  = 0;
  localparam int SRC_TMR0  = 1;
  localparam int SRC_EXT1  = 2;
  localparam int SRC_TMR1  = 3;
  localparam int SRC_UART  = 4;
  localparam int SRC_BROWN = 5;
  localparam int SRC_WDOG  = 6;
  localparam int SRC_TWI   = 7;
  localparam int SRC_KEYP  = 8;
  localparam int SRC_CMP2  = 9;
  localparam int SRC_CONV  = 10;
  localparam int SRC_CMP1  = 11;
  localparam int SRC_BTMO  = 12;
  // Bit positions inside the two enable/priority registers
  localparam int A_EXT0  = 0;
  localparam int A_TMR0  = 1;
  localparam int A_EXT1  = 2;
  localparam int A_TMR1  = 3;
  localparam int A_UART  = 4;
  localparam int A_BROWN = 5;
  localparam int A_WDOG  = 6;
  localparam int A_GATE  = 7;
  localparam int B_TWI   = 0;
  localparam int B_KEYP  = 1;
  localparam int B_CMP2  = 2;
  localparam int B_CONV  = 4;
  localparam int B_CMP1  = 5;
  localparam int B_BTMO  = 7;
  // Vector addresses
  localparam logic [15:0] VEC_EXT0  = 16'h0003;
  localparam logic [15:0] VEC_TMR0  = 16'h000B;
  localparam logic [15:0] VEC_EXT1  = 16'h0013;
  localparam logic [15:0] VEC_TMR1  = 16'h001B;
  localparam logic [15:0] VEC_UART  = 16'h0023;
  localparam logic [15:0] VEC_BROWN = 16'h002B;
  localparam logic [15:0] VEC_TWI   = 16'h0033;
  localparam logic [15:0] VEC_KEYP  = 16'h003B;
  localparam logic [15:0] VEC_CMP2  = 16'h0043;
  localparam logic [15:0] VEC_WDOG  = 16'h0053;
  localparam logic [15:0] VEC_CONV  = 16'h005B;
  localparam logic [15:0] VEC_CMP1  = 16'h0063;
  localparam logic [15:0] VEC_BTMO  = 16'h0073;
  // Power-down wake capable sources
  localparam logic [12:0] WAKE_MASK = 13'h0F65;
  // One machine cycle is six CPU clocks
  localparam int MCYC_CLKS = 6;
  localparam logic [2:0] MCYC_LAST = 3'(MCYC_CLKS - 1);
  localparam logic [2:0] MCYC_RST  = 3'h0;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [1:0] LVL_RST   = 2'h0;
  typedef logic [1:0] fic_level_t;
  // Controller state: running, or servicing an interrupt
  typedef enum logic [1:0] {
    FIC_RUN  = 2'b00,
    FIC_SERV = 2'b01
  } fic_state_t;
  // Winning request handed to the core
  typedef struct packed {
    logic        valid;
    logic [3:0]  src;
    logic [1:0]  level;
    logic [15:0] vector;
  } fic_req_t;
  // Configuration bundle
  typedef struct packed {
    logic [7:0] en_a;
    logic [7:0] en_b;
    logic [7:0] plo_a;
    logic [7:0] phi_a;
    logic [7:0] plo_b;
    logic [7:0] phi_b;
  } fic_cfg_t;
endpackage

/* File: rtl/fic_ext_irq.sv */
// External interrupt pin sampler with level or edge trigger
`timescale 1ns/100ps
module fic_ext_irq (
  // Clock and reset
  input  wire logic CLK,
  input  wire logic RESETN,
  // Pin and machine cycle tick
  input  wire logic pin_n,
  input  wire logic mcyc_tick,
  // Control
  input  wire logic edge_select,
  input  wire logic vector_ack,
  // Request flag
  output logic      request_flag
);
  logic sync1;
  logic sync2;
  logic prev_sample;
  logic cur_sample;
  logic edge_seen;
  logic next_flag;

  // Two flops guard against metastability on the asynchronous pin
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= pin_n;
      sync2 <= sync1;
    end
  end

  // Sample once per machine cycle
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cur_sample  <= 1'b1;
      prev_sample <= 1'b1;
    end else if (mcyc_tick) begin
      prev_sample <= cur_sample;
      cur_sample  <= sync2;
    end
  end

  // High sample followed by low sample
  assign edge_seen = mcyc_tick & cur_sample & ~sync2; // RQ12

  // Level mode tracks the pin; edge mode sets and is cleared on vectoring,
  // with a new edge winning over the clear
  assign next_flag = !edge_select ? ~cur_sample :               // RQ11 RQ18
                     edge_seen    ? 1'b1 :                      // RQ12
                     vector_ack   ? 1'b0 : request_flag;        // RQ15

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) request_flag <= 1'b0;
    else         request_flag <= next_flag; // RQ17
  end

  a_edge_sets_flag: assert property (@(posedge CLK) disable iff (!RESETN)
    (edge_select && edge_seen) |=> request_flag) // RQ12
    else $error("edge did not set request flag");
  a_level_follows: assert property (@(posedge CLK) disable iff (!RESETN)
    (!edge_select && $stable(edge_select)) |=> request_flag == ~$past(cur_sample)) // RQ18
    else $error("level flag does not track pin");
  a_edge_clear: assert property (@(posedge CLK) disable iff (!RESETN)
    (edge_select && vector_ack && !edge_seen) |=> !request_flag) // RQ15
    else $error("edge flag not cleared on vectoring");
endmodule

/* File: rtl/fic_top.sv */
// Four level interrupt controller: arbitration, nesting and vectoring
// Function
// RQ1 - Thirteen request sources arbitrated over four priority levels.
// RQ2 - Each source has an enable bit; global gate blocks all.
// RQ3 - Priority level per source from low and high priority registers.
// RQ4 - Only strictly higher level preempts; top level never preempted.
// RQ5 - Simultaneous requests at different levels: higher level first.
// RQ6 - Same level ties broken by polling order only.
// RQ7 - Fixed tie ranking ext0, brownout, watchdog, timer0 ... bus timeout.
// RQ8 - Each source vectors to its own fixed address eight bytes apart.
// RQ9 - Only external, brownout, keypad, comparators, watchdog, converter wake.
// RQ10 - Serial transmit and receive done share one request and vector.
// RQ11 - Trigger select zero: low level on pin raises request.
// RQ12 - Trigger select one: high sample then low sample sets flag.
// RQ13 - Requester holds pin levels at least six CPU clocks.
// RQ14 - Edge mode: pin high one machine cycle, then low one.
// RQ15 - Edge mode flag cleared automatically when CPU vectors.
// RQ16 - Level mode: pin held low until interrupt taken.
// RQ17 - Level mode: pin still low after handler raises another interrupt.
// RQ18 - Level mode flag follows pin; software need not clear.
// RQ19 - Enabled external interrupt wakes device from power-down or idle.
// RQ20 - High bit and low bit form two-bit level, three highest.
`timescale 1ns/100ps
module fic_top (
  // Clock and reset
  input  wire logic            CLK,
  input  wire logic            RESETN,
  // External interrupt pins, active low
  input  wire logic            EXT0_IRQ_PIN_N,
  input  wire logic            EXT1_IRQ_PIN_N,
  // External trigger selects
  input  wire logic            EXT0_EDGE_SELECT,
  input  wire logic            EXT1_EDGE_SELECT,
  // Enable and priority registers
  input  wire logic [7:0]      IRQ_ENABLE_REG_A,
  input  wire logic [7:0]      IRQ_ENABLE_REG_B,
  input  wire logic [7:0]      PRIORITY_LOW_REG_A,
  input  wire logic [7:0]      PRIORITY_HIGH_REG_A,
  input  wire logic [7:0]      PRIORITY_LOW_REG_B,
  input  wire logic [7:0]      PRIORITY_HIGH_REG_B,
  // On-chip peripheral flags, same clock domain
  input  wire logic            TIMER0_OVERFLOW_FLAG,
  input  wire logic            TIMER1_OVERFLOW_FLAG,
  input  wire logic            UART_TX_DONE_FLAG,
  input  wire logic            UART_RX_DONE_FLAG,
  input  wire logic            BROWNOUT_FLAG,
  input  wire logic            TWOWIRE_ATTENTION_FLAG,
  input  wire logic            KEYPAD_FLAG,
  input  wire logic            COMPARATOR1_FLAG,
  input  wire logic            COMPARATOR2_FLAG,
  input  wire logic            WATCHDOG_OVERFLOW_FLAG,
  input  wire logic            CONVERTER_DONE_FLAG,
  input  wire logic            BUS_TIMEOUT_FLAG,
  // Core handshake
  input  wire logic            VECTOR_ACK,
  input  wire logic            HANDLER_RETURN,
  // Outputs to core
  output fic_pkg::fic_req_t    IRQ_REQUEST,
  output logic                 EXT0_REQUEST_FLAG,
  output logic                 EXT1_REQUEST_FLAG,
  output logic                 WAKE_REQUEST,
  output logic [1:0]           ACTIVE_DEPTH
);
  logic [2:0]               mcyc_cnt;
  logic                     mcyc_tick;
  logic                     ext0_flag;
  logic                     ext1_flag;
  logic                     ack0;
  logic                     ack1;
  logic [fic_pkg::NSRC-1:0] pend;
  logic [fic_pkg::NSRC-1:0] enab;
  logic [fic_pkg::NSRC-1:0] live;
  logic [fic_pkg::NSRC-1:0] plo;
  logic [fic_pkg::NSRC-1:0] phi;
  logic [3:0]               active;
  logic [1:0]               depth;
  logic [2:0]               cur_level;
  logic                     any_active;
  fic_pkg::fic_req_t        win;
  fic_pkg::fic_req_t        taken;
  logic [3:0]               next_active;
  logic                     wake;
  logic [1:0]               top_lvl;

  // Machine cycle divider: one tick per six CPU clocks
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) mcyc_cnt <= fic_pkg::MCYC_RST;
    else if (mcyc_tick) mcyc_cnt <= fic_pkg::MCYC_RST;
    else mcyc_cnt <= mcyc_cnt + 3'h1;
  end
  assign mcyc_tick = (mcyc_cnt == fic_pkg::MCYC_LAST);

  // Clear of an edge flag happens only when its own vector is taken
  assign ack0 = VECTOR_ACK & IRQ_REQUEST.valid
              & (IRQ_REQUEST.src == 4'(fic_pkg::SRC_EXT0));
  assign ack1 = VECTOR_ACK & IRQ_REQUEST.valid
              & (IRQ_REQUEST.src == 4'(fic_pkg::SRC_EXT1));

  fic_ext_irq u_ext0 (
    .CLK          (CLK),
    .RESETN       (RESETN),
    .pin_n        (EXT0_IRQ_PIN_N),
    .mcyc_tick    (mcyc_tick),
    .edge_select  (EXT0_EDGE_SELECT),
    .vector_ack   (ack0),
    .request_flag (ext0_flag)
  );
  fic_ext_irq u_ext1 (
    .CLK          (CLK),
    .RESETN       (RESETN),
    .pin_n        (EXT1_IRQ_PIN_N),
    .mcyc_tick    (mcyc_tick),
    .edge_select  (EXT1_EDGE_SELECT),
    .vector_ack   (ack1),
    .request_flag (ext1_flag)
  );

  // Gather thirteen sources into source order
  assign pend = {BUS_TIMEOUT_FLAG, COMPARATOR1_FLAG, CONVERTER_DONE_FLAG,
                 COMPARATOR2_FLAG, KEYPAD_FLAG, TWOWIRE_ATTENTION_FLAG,
                 WATCHDOG_OVERFLOW_FLAG, BROWNOUT_FLAG,
                 UART_TX_DONE_FLAG | UART_RX_DONE_FLAG,           // RQ10
                 TIMER1_OVERFLOW_FLAG, ext1_flag,
                 TIMER0_OVERFLOW_FLAG, ext0_flag};                // RQ1

  // Map register bits to sources
  function automatic logic [12:0] pick(input logic [7:0] a,
                                       input logic [7:0] b);
    pick = {b[fic_pkg::B_BTMO], b[fic_pkg::B_CMP1], b[fic_pkg::B_CONV],
            b[fic_pkg::B_CMP2], b[fic_pkg::B_KEYP], b[fic_pkg::B_TWI],
            a[fic_pkg::A_WDOG], a[fic_pkg::A_BROWN], a[fic_pkg::A_UART],
            a[fic_pkg::A_TMR1], a[fic_pkg::A_EXT1], a[fic_pkg::A_TMR0],
            a[fic_pkg::A_EXT0]};
  endfunction

  assign enab = pick(IRQ_ENABLE_REG_A, IRQ_ENABLE_REG_B);         // RQ2
  assign plo  = pick(PRIORITY_LOW_REG_A, PRIORITY_LOW_REG_B);     // RQ3
  assign phi  = pick(PRIORITY_HIGH_REG_A, PRIORITY_HIGH_REG_B);   // RQ3
  assign live = pend & enab
              & {fic_pkg::NSRC{IRQ_ENABLE_REG_A[fic_pkg::A_GATE]}}; // RQ2

  // Vector per source
  function automatic logic [15:0] vec_of(input logic [3:0] s);
    case (s)
      4'h0:    vec_of = fic_pkg::VEC_EXT0;
      4'h1:    vec_of = fic_pkg::VEC_TMR0;
      4'h2:    vec_of = fic_pkg::VEC_EXT1;
      4'h3:    vec_of = fic_pkg::VEC_TMR1;
      4'h4:    vec_of = fic_pkg::VEC_UART;
      4'h5:    vec_of = fic_pkg::VEC_BROWN;
      4'h6:    vec_of = fic_pkg::VEC_WDOG;
      4'h7:    vec_of = fic_pkg::VEC_TWI;
      4'h8:    vec_of = fic_pkg::VEC_KEYP;
      4'h9:    vec_of = fic_pkg::VEC_CMP2;
      4'hA:    vec_of = fic_pkg::VEC_CONV;
      4'hB:    vec_of = fic_pkg::VEC_CMP1;
      default: vec_of = fic_pkg::VEC_BTMO;
    endcase // RQ8
  endfunction

  // Tie ranking, position 0 polled first
  function automatic logic [3:0] rank_src(input int r);
    case (r)
      0:       rank_src = 4'(fic_pkg::SRC_EXT0);
      1:       rank_src = 4'(fic_pkg::SRC_BROWN);
      2:       rank_src = 4'(fic_pkg::SRC_WDOG);
      3:       rank_src = 4'(fic_pkg::SRC_TMR0);
      4:       rank_src = 4'(fic_pkg::SRC_TWI);
      5:       rank_src = 4'(fic_pkg::SRC_CONV);
      6:       rank_src = 4'(fic_pkg::SRC_EXT1);
      7:       rank_src = 4'(fic_pkg::SRC_KEYP);
      8:       rank_src = 4'(fic_pkg::SRC_CMP1);
      9:       rank_src = 4'(fic_pkg::SRC_TMR1);
      10:      rank_src = 4'(fic_pkg::SRC_CMP2);
      11:      rank_src = 4'(fic_pkg::SRC_UART);
      default: rank_src = 4'(fic_pkg::SRC_BTMO);
    endcase // RQ7
  endfunction

  // Highest level wins; within a level the first in polling order wins.
  // Scanning in reverse rank with >= lets earlier rank overwrite on ties.
  always_comb begin
    logic [3:0] s;
    logic [1:0] l;
    s   = 4'h0;
    l   = 2'h0;
    win = '0;
    for (int r = fic_pkg::NSRC - 1; r >= 0; r--) begin
      s = rank_src(r);
      l = {phi[s], plo[s]};                                       // RQ20
      if (live[s] && (!win.valid || l >= win.level)) begin        // RQ5 RQ6
        win.valid = 1'b1;
        win.src   = s;
        win.level = l;
      end
    end
    win.vector = vec_of(win.src);                                 // RQ8
  end

  // Top live level, found apart from the scan so the scan can be checked
  assign top_lvl = {|(live & phi),
                    |(live & phi) ? |(live & phi & plo) : |(live & plo)};

  // Nesting: one active bit per level; current level is the top one set
  assign any_active = |active;
  assign cur_level  = active[3] ? 3'h3 : active[2] ? 3'h2 :
                      active[1] ? 3'h1 : 3'h0;
  assign depth      = 2'(active[0] + active[1] + active[2] + active[3]);

  // Offer only a strictly higher level than the one in service
  always_comb begin
    taken = win;
    if (any_active && ({1'b0, win.level} <= cur_level))
      taken.valid = 1'b0;                                         // RQ4
  end

  // Take on ack; return clears the highest active level
  always_comb begin
    next_active = active;
    if (HANDLER_RETURN) begin
      if (active[3])      next_active[3] = 1'b0;
      else if (active[2]) next_active[2] = 1'b0;
      else if (active[1]) next_active[1] = 1'b0;
      else                next_active[0] = 1'b0;
    end
    if (VECTOR_ACK && IRQ_REQUEST.valid)
      next_active[IRQ_REQUEST.level] = 1'b1;                      // RQ4
  end

  // Pending wake-capable source, enabled, ignoring the global gate
  assign wake = |(pend & enab & fic_pkg::WAKE_MASK);              // RQ9 RQ19

  // A request withdrawn or outranked is dropped; after an ack the offer
  // is blanked for one cycle so the same source is not offered twice.
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      active            <= 4'h0;
      IRQ_REQUEST       <= '0;
      EXT0_REQUEST_FLAG <= 1'b0;
      EXT1_REQUEST_FLAG <= 1'b0;
      WAKE_REQUEST      <= 1'b0;
      ACTIVE_DEPTH      <= fic_pkg::LVL_RST;
    end else begin
      active            <= next_active;
      IRQ_REQUEST       <= (VECTOR_ACK && IRQ_REQUEST.valid) ? '0 : taken;
      EXT0_REQUEST_FLAG <= ext0_flag;
      EXT1_REQUEST_FLAG <= ext1_flag;
      WAKE_REQUEST      <= wake;
      ACTIVE_DEPTH      <= depth;
    end
  end

  // Checks
  sequence s_taken;
    VECTOR_ACK && IRQ_REQUEST.valid;
  endsequence
  sequence s_return_only;
    HANDLER_RETURN && !VECTOR_ACK;
  endsequence

  a_gate_blocks: assert property (@(posedge CLK) disable iff (!RESETN)
    !IRQ_ENABLE_REG_A[fic_pkg::A_GATE] [*2] |-> !IRQ_REQUEST.valid) // RQ2
    else $error("request offered while gate closed");
  a_top_never_preempted: assert property (@(posedge CLK)
    disable iff (!RESETN) active[3] |-> !IRQ_REQUEST.valid) // RQ4
    else $error("top level handler preempted");
  a_strictly_higher: assert property (@(posedge CLK) disable iff (!RESETN)
    (IRQ_REQUEST.valid && $past(any_active))
    |-> {1'b0, IRQ_REQUEST.level} > $past(cur_level)) // RQ4
    else $error("preemption at same or lower level");
  a_higher_level_wins: assert property (@(posedge CLK) disable iff (!RESETN)
    IRQ_REQUEST.valid |-> IRQ_REQUEST.level == $past(top_lvl)) // RQ5
    else $error("offered level is not the top live level");
  a_ext0_first_tie: assert property (@(posedge CLK) disable iff (!RESETN)
    (live[fic_pkg::SRC_EXT0] && win.valid
     && {phi[0], plo[0]} == win.level) |-> win.src == 4'h0) // RQ7
    else $error("ranking tie not won by ext0");
  a_vector_match: assert property (@(posedge CLK) disable iff (!RESETN)
    IRQ_REQUEST.valid |-> IRQ_REQUEST.vector == vec_of(IRQ_REQUEST.src)) // RQ8
    else $error("vector does not match source");
  a_timer_no_wake: assert property (@(posedge CLK) disable iff (!RESETN)
    (pend & fic_pkg::WAKE_MASK) == 13'h0000 |=> !WAKE_REQUEST) // RQ9
    else $error("wake from non-wake source");
  a_uart_shared: assert property (@(posedge CLK) disable iff (!RESETN)
    (UART_RX_DONE_FLAG && !UART_TX_DONE_FLAG) |-> pend[fic_pkg::SRC_UART]) // RQ10
    else $error("serial receive flag not on shared line");
  a_ack_nests: assert property (@(posedge CLK) disable iff (!RESETN)
    s_taken ##0 !HANDLER_RETURN |=> active[$past(IRQ_REQUEST.level)]) // RQ4
    else $error("taken request not marked active");
  a_level_reraise: assert property (@(posedge CLK) disable iff (!RESETN)
    (!EXT0_EDGE_SELECT && ext0_flag && enab[0]
     && IRQ_ENABLE_REG_A[fic_pkg::A_GATE] && !any_active
     && !IRQ_REQUEST.valid && !VECTOR_ACK) |=> IRQ_REQUEST.valid) // RQ17
    else $error("held level not re-raised");
  a_ack_blanks: assert property (@(posedge CLK) disable iff (!RESETN) // RQ4
    s_taken |=> !IRQ_REQUEST.valid)
    else $error("offer not withdrawn after vectoring");
  a_return_pops: assert property (@(posedge CLK) disable iff (!RESETN) // RQ4
    s_return_only ##0 active[3] |=> !active[3])
    else $error("return did not end top level service");
  a_ext_wakes: assert property (@(posedge CLK) disable iff (!RESETN) // RQ19
    (ext0_flag && enab[fic_pkg::SRC_EXT0]) |=> WAKE_REQUEST)
    else $error("enabled external request did not wake");
endmodule

/* File: test/fic_core_model.sv */
// Core and external requester model facing the controller
`timescale 1ns/100ps
module fic_core_model (
  // Clock and reset
  input  wire logic         CLK,
  input  wire logic         RESETN,
  // Offered request and take control
  input  fic_pkg::fic_req_t IRQ_REQUEST,
  input  wire logic         ack_en,
  input  wire logic [2:0]   ack_dly,
  // Core handshake and pins
  output logic              VECTOR_ACK,
  output logic              HANDLER_RETURN,
  output logic [1:0]        pin_n,
  // Last taken request
  output fic_pkg::fic_req_t taken,
  output int                taken_cnt
);
  fic_pkg::fic_req_t v;
  logic              a;
  logic              go;
  int                cnt;
  initial begin
    VECTOR_ACK = 1'h0;
    HANDLER_RETURN = 1'h0;
    pin_n = 2'h3;
    taken = '0;
    taken_cnt = 0;
    cnt = 0;
  end
  // Sampled at the edge; acks only a valid offer, dropped after one edge
  always @(posedge CLK) begin
    v = IRQ_REQUEST;
    a = VECTOR_ACK;
    go = v.valid && ack_en && RESETN;
    if (a) begin
      taken = v;
      taken_cnt++;
    end
    #1;
    if (a) begin
      VECTOR_ACK = 1'h0;
    end else if (go && cnt >= ack_dly) begin
      VECTOR_ACK = 1'h1;
      cnt = 0;
    end else begin
      cnt = go ? cnt + 1 : 0;
    end
  end
  // Eight clocks per level, more than one machine cycle
  task automatic drive_pin(input int n, input logic lvl);
    pin_n[n] = lvl;
    repeat (8) @(posedge CLK);
    #1;
  endtask
  task automatic ret_pulse();
    HANDLER_RETURN = 1'h1;
    @(posedge CLK);
    #1;
    HANDLER_RETURN = 1'h0;
  endtask
endmodule

/* File: test/tb_four_level_interrupt_controller.sv */
// Self-checking bench for the four level interrupt controller
`timescale 1ns/100ps
module tb_four_level_interrupt_controller;
  localparam int POSN[13] = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 12, 13, 15};
  localparam int ORD[13]  = '{0, 5, 6, 1, 7, 10, 2, 8, 11, 3, 9, 4, 12};
  localparam logic [15:0] VTAB[13] = '{16'h0003, 16'h000B, 16'h0013,
    16'h001B, 16'h0023, 16'h002B, 16'h0053, 16'h0033, 16'h003B,
    16'h0043, 16'h005B, 16'h0063, 16'h0073};
  localparam logic [12:0] WAKE = 13'h0F65;
  logic              CLK = 1'h0;
  logic              RESETN = 1'h0;
  logic [12:0]       flg = 13'h0000;
  logic              rx = 1'h0;
  logic [1:0]        esel = 2'h0;
  logic              gate = 1'h0;
  fic_pkg::fic_cfg_t cfg = '0;
  logic              ack_en = 1'h0;
  logic [2:0]        ack_dly = 3'h0;
  logic [1:0]        lv [13];
  fic_pkg::fic_req_t rq, tk;
  logic              ack, ret, f0, f1, wk;
  logic [1:0]        dep, pin_n;
  int                tkc, num_errors = 0, total_checks = 0;
  always #20 CLK = ~CLK;
  fic_top dut (
    .CLK(CLK), .RESETN(RESETN),
    .EXT0_IRQ_PIN_N(pin_n[0]), .EXT1_IRQ_PIN_N(pin_n[1]),
    .EXT0_EDGE_SELECT(esel[0]), .EXT1_EDGE_SELECT(esel[1]),
    .IRQ_ENABLE_REG_A({gate, cfg.en_a[6:0]}), .IRQ_ENABLE_REG_B(cfg.en_b),
    .PRIORITY_LOW_REG_A(cfg.plo_a), .PRIORITY_HIGH_REG_A(cfg.phi_a),
    .PRIORITY_LOW_REG_B(cfg.plo_b), .PRIORITY_HIGH_REG_B(cfg.phi_b),
    .TIMER0_OVERFLOW_FLAG(flg[1]), .TIMER1_OVERFLOW_FLAG(flg[3]),
    .UART_TX_DONE_FLAG(flg[4]), .UART_RX_DONE_FLAG(rx),
    .BROWNOUT_FLAG(flg[5]), .TWOWIRE_ATTENTION_FLAG(flg[7]),
    .KEYPAD_FLAG(flg[8]), .COMPARATOR1_FLAG(flg[11]),
    .COMPARATOR2_FLAG(flg[9]), .WATCHDOG_OVERFLOW_FLAG(flg[6]),
    .CONVERTER_DONE_FLAG(flg[10]), .BUS_TIMEOUT_FLAG(flg[12]),
    .VECTOR_ACK(ack), .HANDLER_RETURN(ret), .IRQ_REQUEST(rq),
    .EXT0_REQUEST_FLAG(f0), .EXT1_REQUEST_FLAG(f1), .WAKE_REQUEST(wk),
    .ACTIVE_DEPTH(dep));
  fic_core_model core (
    .CLK(CLK), .RESETN(RESETN), .IRQ_REQUEST(rq), .ack_en(ack_en),
    .ack_dly(ack_dly), .VECTOR_ACK(ack), .HANDLER_RETURN(ret),
    .pin_n(pin_n), .taken(tk), .taken_cnt(tkc));
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic cfg_set(input logic [12:0] m);
    logic [15:0] e, lo, hi;
    e = 16'h0000;
    lo = 16'h0000;
    hi = 16'h0000;
    for (int i = 0; i < 13; i++) begin
      e[POSN[i]] = m[i];
      lo[POSN[i]] = lv[i][0];
      hi[POSN[i]] = lv[i][1];
    end
    cfg = {e[7:0], e[15:8], lo[7:0], hi[7:0], lo[15:8], hi[15:8]};
  endtask
  function automatic int rnk(input int s);
    for (int k = 0; k < 13; k++)
      if (ORD[k] == s)
        return k;
    return 13;
  endfunction
  // Highest level first, ranking only among equals
  function automatic int win(input logic [12:0] m);
    int b;
    b = -1;
    for (int i = 0; i < 13; i++)
      if (m[i] && (b < 0 || lv[i] > lv[b] ||
          (lv[i] == lv[b] && rnk(i) < rnk(b))))
        b = i;
    return b;
  endfunction
  // Random ack latency exercises prompt and slow cores
  task automatic take(input int s, input logic [1:0] l);
    int n0;
    n0 = tkc;
    ack_dly = 3'($urandom_range(3));
    ack_en = 1'h1;
    for (int i = 0; i < 40 && tkc == n0; i++)
      step(1);
    ack_en = 1'h0;
    chk("taken", 16'(n0 + 1), 16'(tkc));
    chk("src", 16'(s), 16'(tk.src));
    chk("vector", VTAB[s], tk.vector);
    chk("level", 16'(l), 16'(tk.level));
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge CLK);
    num_errors++;
    print_verdict();
  end
  initial begin
    logic [12:0] m, e;
    logic [1:0]  l;
    int          q, w;
    void'($urandom(85158));
    foreach (lv[i]) lv[i] = 2'h0;
    step(9);
    chk("reset valid", 16'h0, 16'(rq.valid));
    chk("reset depth", 16'h0, 16'(dep));
    step(1);
    RESETN = 1'h1;
    gate = 1'h1;
    // Each on-chip source alone; index 13 is the receive half of the serial line
    for (int s = 1; s < 14; s++) begin
      q = (s == 13) ? 4 : s;
      if (q == 2)
        continue;
      cfg_set(13'(1) << q);
      if (s == 13)
        rx = 1'h1;
      else
        flg[q] = 1'h1;
      step(3);
      chk("wake", 16'(WAKE[q]), 16'(wk));
      take(q, 2'h0);
      flg = 13'h0000;
      rx = 1'h0;
      step(2);
      chk("depth", 16'h1, 16'(dep));
      core.ret_pulse();
      step(2);
      chk("depth", 16'h0, 16'(dep));
    end
    // Everything pending at one level; gate closed first
    l = 2'($urandom_range(3));
    foreach (lv[i]) lv[i] = l;
    gate = 1'h0;
    cfg_set(13'h1FFF);
    flg = 13'h1FFF;
    core.drive_pin(0, 1'h0);
    core.drive_pin(1, 1'h0);
    step(4);
    chk("gate", 16'h0, 16'(rq.valid));
    gate = 1'h1;
    for (int k = 0; k < 13; k++) begin
      take(ORD[k], l);
      if (ORD[k] == 0 || ORD[k] == 2)
        core.drive_pin(ORD[k] / 2, 1'h1);
      else
        flg[ORD[k]] = 1'h0;
      step(12);
      chk("same level", 16'h0, 16'(rq.valid));
      core.ret_pulse();
      step(2);
    end
    // Random pending sets, enables and levels
    for (int r = 0; r < 24; r++) begin
      m = 13'($urandom) & 13'h1FFA;
      e = 13'($urandom);
      if ((m & e) == 13'h0)
        m[12] = 1'h1;
      if ((m & e) == 13'h0)
        e[12] = 1'h1;
      foreach (lv[i]) lv[i] = 2'($urandom_range(3));
      cfg_set(e);
      flg = m;
      step(3);
      w = win(m & e);
      chk("winner", 16'(w), 16'(rq.src));
      take(w, lv[w]);
      flg = 13'h0000;
      core.ret_pulse();
      step(2);
    end
    // Nesting: only a strictly higher level breaks in
    foreach (lv[i]) lv[i] = 2'h0;
    lv[3] = 2'h1;
    lv[1] = 2'h1;
    lv[10] = 2'h2;
    lv[11] = 2'h3;
    lv[12] = 2'h3;
    cfg_set(13'h1FFF);
    flg[3] = 1'h1;
    take(3, 2'h1);
    flg[1] = 1'h1;
    step(4);
    chk("equal held", 16'h0, 16'(rq.valid));
    flg[10] = 1'h1;
    take(10, 2'h2);
    flg[12] = 1'h1;
    step(1);
    take(12, 2'h3);
    flg[11] = 1'h1;
    step(4);
    chk("top held", 16'h0, 16'(rq.valid));
    chk("depth", 16'h3, 16'(dep));
    flg = 13'h0000;
    // Idle edge between pulses keeps each return a separate strobe
    repeat (3) begin
      core.ret_pulse();
      step(1);
    end
    step(2);
    chk("depth", 16'h0, 16'(dep));
    // External pins in edge then level mode
    foreach (lv[i]) lv[i] = 2'h0;
    for (int n = 0; n < 2; n++) begin
      cfg_set(13'(1) << (2 * n));
      esel[n] = 1'h1;
      core.drive_pin(n, 1'h1);
      core.drive_pin(n, 1'h0);
      step(6);
      chk("edge flag", 16'h1, 16'(n ? f1 : f0));
      chk("ext wake", 16'h1, 16'(wk));
      take(2 * n, 2'h0);
      step(2);
      chk("edge clear", 16'h0, 16'(n ? f1 : f0));
      core.ret_pulse();
      step(12);
      chk("no retrigger", 16'h0, 16'(rq.valid));
      esel[n] = 1'h0;
      step(12);
      chk("level flag", 16'h1, 16'(n ? f1 : f0));
      take(2 * n, 2'h0);
      core.ret_pulse();
      step(3);
      chk("level again", 16'h1, 16'(rq.valid));
      take(2 * n, 2'h0);
      core.drive_pin(n, 1'h1);
      step(12);
      chk("level low", 16'h0, 16'(n ? f1 : f0));
      core.ret_pulse();
      step(2);
    end
    print_verdict();
  end
endmodule
